// [hw/dps_pkg.sv]
package dps_pkg;
  // parameter numbers within the protection group, as keyed in on the keypad
  localparam logic [4:0] DPS_IDX_VREG = 5'h08;
  localparam logic [4:0] DPS_IDX_INLOSS_SEL = 5'h09;
  localparam logic [4:0] DPS_IDX_OUTLOSS_SEL = 5'h0a;
  localparam logic [4:0] DPS_IDX_HT_SEL = 5'h0d;
  localparam logic [4:0] DPS_IDX_HT_ACT = 5'h0e;
  localparam logic [4:0] DPS_IDX_HT_LVL = 5'h0f;
  localparam logic [4:0] DPS_IDX_HT_TIME = 5'h10;
  localparam logic [4:0] DPS_IDX_LT_SEL = 5'h11;
  localparam logic [4:0] DPS_IDX_LT_ACT = 5'h12;
  localparam logic [4:0] DPS_IDX_LT_LVL = 5'h13;
  localparam logic [4:0] DPS_IDX_LT_TIME = 5'h14;
  localparam logic [4:0] DPS_IDX_LEAK_SEL = 5'h17;
  localparam logic [4:0] DPS_IDX_EXT_ACT = 5'h18;
  localparam logic [4:0] DPS_IDX_EXT_TIME = 5'h19;
  // storage slots
  localparam int DPS_NREG = 14;
  localparam logic [3:0] DPS_S_VREG = 4'h0;
  localparam logic [3:0] DPS_S_INLOSS = 4'h1;
  localparam logic [3:0] DPS_S_OUTLOSS = 4'h2;
  localparam logic [3:0] DPS_S_HTSEL = 4'h3;
  localparam logic [3:0] DPS_S_HTACT = 4'h4;
  localparam logic [3:0] DPS_S_HTLVL = 4'h5;
  localparam logic [3:0] DPS_S_HTTIME = 4'h6;
  localparam logic [3:0] DPS_S_LTSEL = 4'h7;
  localparam logic [3:0] DPS_S_LTACT = 4'h8;
  localparam logic [3:0] DPS_S_LTLVL = 4'h9;
  localparam logic [3:0] DPS_S_LTTIME = 4'ha;
  localparam logic [3:0] DPS_S_LEAK = 4'hb;
  localparam logic [3:0] DPS_S_EXTACT = 4'hc;
  localparam logic [3:0] DPS_S_EXTTIME = 4'hd;
  localparam logic [3:0] DPS_S_NONE = 4'hf;
  // setting ranges and reset values
  localparam logic [15:0] DPS_LVL_MAX = 16'h012c;   // 300 percent
  localparam logic [15:0] DPS_TIME_MAX = 16'h0064;  // 10.0 s in 0.1 s steps
  localparam logic [15:0] DPS_SEL2_MAX = 16'h0002;
  localparam logic [15:0] DPS_SEL1_MAX = 16'h0001;
  localparam logic [15:0] DPS_RST_LVL = 16'h0096;   // 150 percent
  localparam logic [15:0] DPS_RST_TIME = 16'h0001;  // 0.1 s
  localparam logic [15:0] DPS_RST_LO_LVL = 16'h001e; // 30 percent
  // setting codes
  localparam logic [15:0] DPS_OFF = 16'h0000;
  localparam logic [15:0] DPS_ON = 16'h0001;
  localparam logic [15:0] DPS_DET_AT_SPEED = 16'h0001;
  localparam logic [15:0] DPS_DET_AT_RUN = 16'h0002;
  localparam logic [15:0] DPS_ACT_DECEL = 16'h0000;
  localparam logic [15:0] DPS_ACT_COAST = 16'h0001;
  localparam logic [15:0] DPS_ACT_CONT = 16'h0002;
  localparam logic [15:0] DPS_ACT_WARN = 16'h0001;
  localparam logic [15:0] DPS_EXT_AT_RUN = 16'h0001;
  // gating levels in percent of rated current
  localparam logic [15:0] DPS_INLOSS_MIN_PCT = 16'h001e; // 30
  localparam logic [15:0] DPS_OUTLOSS_MIN_PCT = 16'h000a; // 10
  localparam logic [15:0] DPS_LEAK_PCT = 16'h0032; // 50
  // relay function codes
  localparam logic [7:0] DPS_DO_HI_TORQUE = 8'h0c;    // 12
  localparam logic [7:0] DPS_DO_LO_TORQUE = 8'h19;    // 25
  // control methods
  localparam logic [1:0] DPS_MODE_VF = 2'h0;
  localparam logic [1:0] DPS_MODE_VF_ENC = 2'h1;
  // timing: detection time unit is 0.1 s
  localparam longint DPS_TIME_UNIT_NS = 100000000;
  localparam longint DPS_CLK_NS = 4;
  localparam int DPS_TICK_CYCLES = int'(DPS_TIME_UNIT_NS / DPS_CLK_NS);
  // keypad fault and warning codes
  localparam logic [3:0] DPS_F_NONE = 4'h0;
  localparam logic [3:0] DPS_F_INLOSS = 4'h1;
  localparam logic [3:0] DPS_F_OUTLOSS = 4'h2;
  localparam logic [3:0] DPS_F_LEAK = 4'h3;
  localparam logic [3:0] DPS_F_HT = 4'h4;
  localparam logic [3:0] DPS_F_LT = 4'h5;
  localparam logic [3:0] DPS_F_EXT = 4'h6;
  // supervisor states
  typedef enum logic [2:0] {
    DPS_ST_OK = 3'b001,
    DPS_ST_WARN = 3'b010,
    DPS_ST_TRIP = 3'b100
  } dps_state_type;
endpackage

// [hw/dps_supervisor.sv]
`timescale 1ns/100ps
module dps_supervisor
  import dps_pkg::*;
#(
  parameter int TICK_CYCLES = DPS_TICK_CYCLES // cycles per 0.1 s step
)(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic param_wr_in,           // parameter write strobe
  input wire logic param_rd_in,           // parameter read strobe
  input wire logic [4:0] param_idx_in,    // parameter number in group
  input wire logic [15:0] param_wdata_in, // value to store
  input wire logic run_in,                // run command active
  input wire logic at_speed_in,           // output reached set frequency
  input wire logic [1:0] control_mode_in, // control method
  input wire logic [15:0] out_current_pct_in, // percent of rated current
  input wire logic [15:0] torque_pct_in,  // percent of rated torque
  input wire logic [15:0] leakage_pct_in, // leakage, percent of rated
  input wire logic in_phase_loss_in,      // input loss sensed
  input wire logic out_phase_loss_in,     // output loss sensed
  input wire logic ext_fault_in,          // external fault terminal
  input wire logic fault_reset_in,        // keypad or terminal reset
  input wire logic [7:0] relay_one_func_in, // function of relay one
  input wire logic [7:0] relay_two_func_in, // function of relay two
  output logic [15:0] param_rd_data_out,  // read value, next cycle
  output logic param_rd_valid_out,        // read value valid
  output logic param_wr_err_out,          // last write refused
  output logic automatic_voltage_regulation_out, // regulate output volts
  output logic [3:0] fault_code_out,      // keypad fault display
  output logic [3:0] warn_code_out,       // keypad warning display
  output logic fault_contact_out,         // fault relay contact
  output logic coast_stop_out,            // free-run stop request
  output logic decel_stop_out,            // ramp-down stop request
  output logic relay_output_one_out,      // multi-function relay one
  output logic relay_output_two_out       // multi-function relay two
);

  // everything that is stored lives in this one record
  typedef struct packed {
    logic [DPS_NREG-1:0][15:0] regs; // parameter settings
    logic [31:0] tick_cnt;  // divider for the 0.1 s enable
    logic tick;             // one-cycle 0.1 s enable
    logic [15:0] ht_cnt;    // over-torque dwell, in steps
    logic [15:0] lt_cnt;    // low-torque dwell, in steps
    logic ht_det;           // over-torque detected
    logic lt_det;           // low-torque detected
    logic run_seen;         // a run has started since reset
    dps_state_type st;      // supervisor state
    logic [3:0] fault;
    logic [3:0] warn;
    logic contact;
    logic coast;
    logic decel;
    logic relay1;
    logic relay2;
    logic regulate;
    logic [15:0] rd_data;
    logic rd_valid;
    logic wr_err;
  } dps_regs_type;

  dps_regs_type s_q;
  dps_regs_type s_d;

  // parameter number to storage slot, used by read and write
  function automatic logic [3:0] slot_of(input logic [4:0] idx);
    case (idx)
      DPS_IDX_VREG: slot_of = DPS_S_VREG;
      DPS_IDX_INLOSS_SEL: slot_of = DPS_S_INLOSS;
      DPS_IDX_OUTLOSS_SEL: slot_of = DPS_S_OUTLOSS;
      DPS_IDX_HT_SEL: slot_of = DPS_S_HTSEL;
      DPS_IDX_HT_ACT: slot_of = DPS_S_HTACT;
      DPS_IDX_HT_LVL: slot_of = DPS_S_HTLVL;
      DPS_IDX_HT_TIME: slot_of = DPS_S_HTTIME;
      DPS_IDX_LT_SEL: slot_of = DPS_S_LTSEL;
      DPS_IDX_LT_ACT: slot_of = DPS_S_LTACT;
      DPS_IDX_LT_LVL: slot_of = DPS_S_LTLVL;
      DPS_IDX_LT_TIME: slot_of = DPS_S_LTTIME;
      DPS_IDX_LEAK_SEL: slot_of = DPS_S_LEAK;
      DPS_IDX_EXT_ACT: slot_of = DPS_S_EXTACT;
      DPS_IDX_EXT_TIME: slot_of = DPS_S_EXTTIME;
      default: slot_of = DPS_S_NONE;
    endcase
  endfunction

  // largest legal value of each slot; out-of-range writes are refused
  function automatic logic [15:0] max_of(input logic [3:0] slot);
    case (slot)
      DPS_S_HTSEL, DPS_S_LTSEL, DPS_S_EXTACT: max_of = DPS_SEL2_MAX;
      DPS_S_HTLVL, DPS_S_LTLVL: max_of = DPS_LVL_MAX;
      DPS_S_HTTIME, DPS_S_LTTIME: max_of = DPS_TIME_MAX;
      default: max_of = DPS_SEL1_MAX;
    endcase
  endfunction

  // detection window by selection: off, at speed, or whole run
  function automatic logic det_window(input logic [15:0] sel, input logic run,
                                      input logic at_speed);
    case (sel)
      DPS_DET_AT_SPEED: det_window = run && at_speed;
      DPS_DET_AT_RUN: det_window = run;
      default: det_window = 1'b0;
    endcase
  endfunction

  // relay follows the torque detector named by its function code
  function automatic logic relay_drive(input logic [7:0] func, input logic ht,
                                       input logic lt);
    case (func)
      DPS_DO_HI_TORQUE: relay_drive = ht;
      DPS_DO_LO_TORQUE: relay_drive = lt;
      default: relay_drive = 1'b0;
    endcase
  endfunction

  // reset image of the record
  function automatic dps_regs_type reset_image();
    dps_regs_type r;
    r = '0;
    r.regs[DPS_S_HTLVL] = DPS_RST_LVL;
    r.regs[DPS_S_HTTIME] = DPS_RST_TIME;
    r.regs[DPS_S_LTLVL] = DPS_RST_LO_LVL;
    r.regs[DPS_S_LTTIME] = DPS_RST_TIME;
    r.st = DPS_ST_OK;
    r.regulate = 1'b1;
    return r;
  endfunction

  // combinational helpers shared with the checks
  logic [15:0] torque_meas; // scaled against rated current or torque
  logic ht_cond;
  logic lt_cond;
  logic inloss_hit;
  logic outloss_hit;
  logic leak_hit;
  logic ext_hit;

  // condition terms, kept outside the next-state process for the checks
  always_comb
  begin
    // v/f modes measure current, vector modes torque
    if (control_mode_in == DPS_MODE_VF || control_mode_in == DPS_MODE_VF_ENC)
    begin
      torque_meas = out_current_pct_in;
    end
    else
    begin
      torque_meas = torque_pct_in;
    end
    ht_cond = det_window(s_q.regs[DPS_S_HTSEL], run_in, at_speed_in)
              && (torque_meas > s_q.regs[DPS_S_HTLVL]);
    lt_cond = det_window(s_q.regs[DPS_S_LTSEL], run_in, at_speed_in)
              && (torque_meas < s_q.regs[DPS_S_LTLVL]);
    // light load hides a phase loss, so it must not trip
    inloss_hit = (s_q.regs[DPS_S_INLOSS] == DPS_ON) && in_phase_loss_in
                 && (out_current_pct_in >= DPS_INLOSS_MIN_PCT);
    outloss_hit = (s_q.regs[DPS_S_OUTLOSS] == DPS_ON) && out_phase_loss_in
                  && (out_current_pct_in >= DPS_OUTLOSS_MIN_PCT);
    leak_hit = (s_q.regs[DPS_S_LEAK] == DPS_ON)
               && (leakage_pct_in >= DPS_LEAK_PCT);
    // timing 1 waits for the first run after reset
    ext_hit = ext_fault_in && ((s_q.regs[DPS_S_EXTTIME] != DPS_EXT_AT_RUN)
              || s_q.run_seen || run_in);
  end

  // next-state process
  always_comb
  begin
    logic [3:0] slot;
    logic [3:0] new_fault;
    logic want_coast;
    logic want_decel;
    logic [3:0] new_warn;
    slot = slot_of(param_idx_in);
    new_fault = DPS_F_NONE;
    want_coast = 1'b0;
    want_decel = 1'b0;
    new_warn = DPS_F_NONE;
    s_d = s_q;

    // parameter access; only one of write or read is honoured, write first
    s_d.rd_valid = 1'b0;
    if (param_wr_in)
    begin
      if (slot != DPS_S_NONE && param_wdata_in <= max_of(slot))
      begin
        s_d.regs[slot] = param_wdata_in;
        s_d.wr_err = 1'b0;
      end
      else
      begin
        s_d.wr_err = 1'b1; // unknown number or out of range
      end
    end
    else if (param_rd_in)
    begin
      s_d.rd_valid = 1'b1;
      s_d.rd_data = (slot == DPS_S_NONE) ? 16'h0000 : s_q.regs[slot];
    end

    // 0.1 s enable from the clock divider
    s_d.tick = 1'b0;
    if (s_q.tick_cnt >= 32'(TICK_CYCLES - 1))
    begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h00000001;
    end

    if (run_in)
    begin
      s_d.run_seen = 1'b1;
    end

    // dwell timers: restart on lapse, saturate at the set time
    if (!ht_cond)
    begin
      s_d.ht_cnt = '0;
    end
    else if (s_q.tick && s_q.ht_cnt < s_q.regs[DPS_S_HTTIME])
    begin
      s_d.ht_cnt = s_q.ht_cnt + 16'h0001;
    end
    if (!lt_cond)
    begin
      s_d.lt_cnt = '0;
    end
    else if (s_q.tick && s_q.lt_cnt < s_q.regs[DPS_S_LTTIME])
    begin
      s_d.lt_cnt = s_q.lt_cnt + 16'h0001;
    end
    s_d.ht_det = ht_cond && (s_q.ht_cnt >= s_q.regs[DPS_S_HTTIME]);
    s_d.lt_det = lt_cond && (s_q.lt_cnt >= s_q.regs[DPS_S_LTTIME]);

    // pick the cause; hard faults first, external fault last
    if (inloss_hit)
    begin
      new_fault = DPS_F_INLOSS;
      want_coast = 1'b1;
    end
    else if (outloss_hit)
    begin
      new_fault = DPS_F_OUTLOSS;
      want_coast = 1'b1;
    end
    else if (leak_hit)
    begin
      new_fault = DPS_F_LEAK;
      want_coast = 1'b1;
    end
    else if (s_q.ht_det && s_q.regs[DPS_S_HTACT] == DPS_ACT_DECEL)
    begin
      new_fault = DPS_F_HT;
      want_decel = 1'b1;
    end
    else if (s_q.lt_det && s_q.regs[DPS_S_LTACT] == DPS_ACT_DECEL)
    begin
      new_fault = DPS_F_LT;
      want_decel = 1'b1;
    end
    else if (ext_hit && s_q.regs[DPS_S_EXTACT] == DPS_ACT_DECEL)
    begin
      new_fault = DPS_F_EXT;
      want_decel = 1'b1;
    end
    else if (ext_hit && s_q.regs[DPS_S_EXTACT] == DPS_ACT_COAST)
    begin
      new_fault = DPS_F_EXT;
      want_coast = 1'b1;
    end

    // warnings only show, the drive keeps running
    if (s_q.ht_det && s_q.regs[DPS_S_HTACT] == DPS_ACT_WARN)
    begin
      new_warn = DPS_F_HT;
    end
    else if (s_q.lt_det && s_q.regs[DPS_S_LTACT] == DPS_ACT_WARN)
    begin
      new_warn = DPS_F_LT;
    end
    else if (ext_hit && s_q.regs[DPS_S_EXTACT] == DPS_ACT_CONT)
    begin
      new_warn = DPS_F_EXT;
    end

    // supervisor state; a new cause beats a reset in the same cycle
    case (s_q.st)
      DPS_ST_OK, DPS_ST_WARN:
      begin
        if (new_fault != DPS_F_NONE)
        begin
          s_d.st = DPS_ST_TRIP;
          s_d.fault = new_fault;
          s_d.contact = 1'b1;
          s_d.coast = want_coast;
          s_d.decel = want_decel;
        end
        else if (new_warn != DPS_F_NONE)
        begin
          s_d.st = DPS_ST_WARN;
        end
        else
        begin
          s_d.st = DPS_ST_OK;
        end
      end
      DPS_ST_TRIP:
      begin
        // first cause stays latched until reset
        if (fault_reset_in && new_fault == DPS_F_NONE)
        begin
          s_d.st = DPS_ST_OK;
          s_d.fault = DPS_F_NONE;
          s_d.contact = 1'b0;
          s_d.coast = 1'b0;
          s_d.decel = 1'b0;
        end
      end
      default:
      begin
        s_d.st = DPS_ST_OK;
      end
    endcase
    s_d.warn = new_warn;

    // relays registered from present detector state, regulation from the VREG setting
    s_d.relay1 = relay_drive(relay_one_func_in, s_q.ht_det, s_q.lt_det);
    s_d.relay2 = relay_drive(relay_two_func_in, s_q.ht_det, s_q.lt_det);
    s_d.regulate = (s_q.regs[DPS_S_VREG] == DPS_OFF);
  end

  // state register
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      s_q <= reset_image();
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign param_rd_data_out = s_q.rd_data;
  assign param_rd_valid_out = s_q.rd_valid;
  assign param_wr_err_out = s_q.wr_err;
  assign automatic_voltage_regulation_out = s_q.regulate;
  assign fault_code_out = s_q.fault;
  assign warn_code_out = s_q.warn;
  assign fault_contact_out = s_q.contact;
  assign coast_stop_out = s_q.coast;
  assign decel_stop_out = s_q.decel;
  assign relay_output_one_out = s_q.relay1;
  assign relay_output_two_out = s_q.relay2;

  // checks
  sequence s_vreg_follow;
    param_wr_in && param_idx_in == DPS_IDX_VREG && param_wdata_in == DPS_ON;
  endsequence

  chk_regulation_follow_mode: assert property (@(posedge clock_in) disable iff (rst_in)
    s_vreg_follow |-> ##2 !automatic_voltage_regulation_out)
    else $error("regulation not released after setting 1");

  chk_inloss_trip_cause: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(fault_code_out == DPS_F_INLOSS) |-> $past(out_current_pct_in) >= DPS_INLOSS_MIN_PCT)
    else $error("input loss tripped under light load");

  chk_outloss_trip_cause: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(fault_code_out == DPS_F_OUTLOSS) |-> $past(out_current_pct_in) >= DPS_OUTLOSS_MIN_PCT)
    else $error("output loss tripped under light load");

  chk_inloss_enable_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    (s_q.regs[DPS_S_INLOSS] == DPS_OFF)
    |=> fault_code_out != DPS_F_INLOSS || $stable(fault_code_out))
    else $error("input loss raised while disabled");

  chk_hard_fault_coast: assert property (@(posedge clock_in) disable iff (rst_in)
    (fault_code_out == DPS_F_LEAK || fault_code_out == DPS_F_INLOSS
     || fault_code_out == DPS_F_OUTLOSS)
    |-> coast_stop_out && fault_contact_out && !decel_stop_out)
    else $error("hard fault without coast and contact");

  chk_ht_dwell_time: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(s_q.ht_det) |-> $past(s_q.ht_cnt) >= $past(s_q.regs[DPS_S_HTTIME]) && $past(ht_cond))
    else $error("over-torque asserted before its dwell time");

  chk_lt_lapse_restart: assert property (@(posedge clock_in) disable iff (rst_in)
    !lt_cond |=> s_q.lt_cnt == 16'h0000 ##1 !s_q.lt_det || $past(lt_cond))
    else $error("low-torque timer kept time over a lapse");

  chk_warn_keeps_run: assert property (@(posedge clock_in) disable iff (rst_in)
    (warn_code_out != DPS_F_NONE && fault_code_out == DPS_F_NONE)
    |-> !coast_stop_out && !decel_stop_out)
    else $error("warning stopped the drive");

  chk_relay_route: assert property (@(posedge clock_in) disable iff (rst_in)
    relay_one_func_in == DPS_DO_HI_TORQUE |=> relay_output_one_out == $past(s_q.ht_det))
    else $error("relay one does not follow over-torque");

  chk_fault_latched: assert property (@(posedge clock_in) disable iff (rst_in)
    (fault_code_out != DPS_F_NONE && !fault_reset_in) |=> $stable(fault_code_out))
    else $error("fault display changed without reset");

endmodule

// [testbench/dps_power_stage.sv]
`timescale 1ns/100ps
// stand-in for the power stage and its current, torque and leakage sensing
module dps_power_stage (
  input wire logic clock_in,
  input wire logic run_in,              // run command from the bench
  input wire logic stop_in,             // any stop request of the supervisor
  input wire logic [15:0] cur_set_in,   // wanted current reading
  input wire logic [15:0] trq_set_in,   // wanted torque reading
  input wire logic [15:0] leak_set_in,  // wanted leakage reading
  input wire logic [1:0] loss_set_in,   // bit 0 input loss, bit 1 output loss
  output logic at_speed_out,
  output logic [15:0] cur_out,
  output logic [15:0] trq_out,
  output logic [15:0] leak_out,
  output logic in_loss_out,
  output logic out_loss_out
);
  // sensing lags one cycle, as a sampled measurement would
  always_ff @(posedge clock_in)
  begin
    cur_out <= cur_set_in;
    trq_out <= trq_set_in;
    leak_out <= leak_set_in;
    in_loss_out <= loss_set_in[0];
    out_loss_out <= loss_set_in[1];
    // speed is lost at once on any stop, so the window closes honestly
    at_speed_out <= run_in && !stop_in;
  end
endmodule

// [testbench/dps_supervisor_tb.sv]
`timescale 1ns/100ps
module dps_supervisor_tb;
  import dps_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b0;
  logic frst = 1'b0;
  logic ext = 1'b0;
  logic [4:0] idx = 5'h00;
  logic [15:0] wd = 16'h0000;
  logic [1:0] mode = 2'h0;
  logic [1:0] loss = 2'h0;
  logic [15:0] cur = 16'h0000;
  logic [15:0] trq = 16'h0000;
  logic [15:0] leak = 16'h0000;
  logic [7:0] f1 = 8'h00;
  logic [7:0] f2 = 8'h00;
  logic [15:0] rdata, m_cur, m_trq, m_leak;
  logic rvalid, werr, regul, cont, coast, decel, r1, r2, at_spd, in_loss, out_loss;
  logic [3:0] fcode, wcode;
  int bad_count = 0;
  int checked = 0;
  // four cycles per detection step keeps dwell waits short
  dps_supervisor #(.TICK_CYCLES(4)) dut (.clock_in(clock_in), .rst_in(rst_in),
    .param_wr_in(wr), .param_rd_in(rd), .param_idx_in(idx), .param_wdata_in(wd),
    .run_in(run), .at_speed_in(at_spd), .control_mode_in(mode),
    .out_current_pct_in(m_cur), .torque_pct_in(m_trq), .leakage_pct_in(m_leak),
    .in_phase_loss_in(in_loss), .out_phase_loss_in(out_loss), .ext_fault_in(ext),
    .fault_reset_in(frst), .relay_one_func_in(f1), .relay_two_func_in(f2),
    .param_rd_data_out(rdata), .param_rd_valid_out(rvalid), .param_wr_err_out(werr),
    .automatic_voltage_regulation_out(regul), .fault_code_out(fcode),
    .warn_code_out(wcode), .fault_contact_out(cont), .coast_stop_out(coast),
    .decel_stop_out(decel), .relay_output_one_out(r1), .relay_output_two_out(r2));
  dps_power_stage stage (.clock_in(clock_in), .run_in(run), .stop_in(coast || decel),
    .cur_set_in(cur), .trq_set_in(trq), .leak_set_in(leak), .loss_set_in(loss),
    .at_speed_out(at_spd), .cur_out(m_cur), .trq_out(m_trq), .leak_out(m_leak),
    .in_loss_out(in_loss), .out_loss_out(out_loss));
  // free-running system clock
  always #2 clock_in = ~clock_in;
  // one compare for every kind of value
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // verdict and end of run
  task report_and_stop;
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // wait n edges and return on the edge itself
  task cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // one-cycle write, refusal flag seen a cycle later
  task wr_p(input logic [4:0] i, input logic [15:0] d, input logic e);
    cyc(1);
    wr <= 1'b1;
    idx <= i;
    wd <= d;
    cyc(1);
    wr <= 1'b0;
    #1;
    chk("wr_err", {15'h0000, e}, {15'h0000, werr});
  endtask
  // one-cycle read, data and valid a cycle later
  task rd_p(input logic [4:0] i, input logic [15:0] e);
    cyc(1);
    rd <= 1'b1;
    idx <= i;
    cyc(1);
    rd <= 1'b0;
    #1;
    chk("rd_valid", 16'h0001, {15'h0000, rvalid});
    chk("rd_data", e, rdata);
  endtask
  // fault display, contact, coast, decel and warning at once
  task st(input logic [3:0] f, input logic c, input logic co, input logic d,
          input logic [3:0] w);
    #1;
    chk("status", {5'h00, f, w, c, co, d}, {5'h00, fcode, wcode, cont, coast, decel});
  endtask
  // drop every cause, then clear the latched trip
  task clr;
    cyc(1);
    loss <= 2'h0;
    leak <= 16'h0000;
    ext <= 1'b0;
    run <= 1'b0;
    frst <= 1'b1;
    cyc(3);
    frst <= 1'b0;
    cyc(1);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
  endtask
  // main sequence
  initial
  begin
    cyc(8);
    rst_in <= 1'b0;
    rd_p(DPS_IDX_HT_LVL, DPS_RST_LVL);
    rd_p(DPS_IDX_LT_LVL, DPS_RST_LO_LVL);
    rd_p(DPS_IDX_HT_TIME, DPS_RST_TIME);
    rd_p(5'h1f, 16'h0000);
    chk("regulation", 16'h0001, {15'h0000, regul});
    wr_p(DPS_IDX_VREG, DPS_ON, 1'b0);
    cyc(1);
    #1;
    chk("regulation", 16'h0000, {15'h0000, regul});
    wr_p(DPS_IDX_HT_LVL, 16'h012d, 1'b1);
    wr_p(DPS_IDX_HT_TIME, 16'h0065, 1'b1);
    wr_p(5'h1f, 16'h0000, 1'b1);
    wr_p(DPS_IDX_HT_LVL, DPS_LVL_MAX, 1'b0);
    rd_p(DPS_IDX_HT_LVL, DPS_LVL_MAX);
    wr_p(DPS_IDX_LT_TIME, DPS_TIME_MAX, 1'b0);
    wr_p(DPS_IDX_LT_TIME, DPS_RST_TIME, 1'b0);
    // external fault ignored until a run has been seen
    wr_p(DPS_IDX_EXT_TIME, DPS_EXT_AT_RUN, 1'b0);
    cyc(1);
    ext <= 1'b1;
    cyc(4);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
    cyc(1);
    ext <= 1'b0;
    wr_p(DPS_IDX_EXT_TIME, DPS_OFF, 1'b0);
    // every external action code in turn
    for (int a = 0; a < 3; a++)
    begin
      wr_p(DPS_IDX_EXT_ACT, a[15:0], 1'b0);
      cyc(1);
      ext <= 1'b1;
      cyc(3);
      st((a == 2) ? DPS_F_NONE : DPS_F_EXT, a != 2, a == 1, a == 0,
         (a == 2) ? DPS_F_EXT : DPS_F_NONE);
      clr;
    end
    // input loss: just under and at the current floor
    wr_p(DPS_IDX_INLOSS_SEL, DPS_ON, 1'b0);
    cyc(1);
    loss <= 2'h1;
    cur <= 16'h001d;
    cyc(4);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
    cyc(1);
    cur <= 16'h001e;
    cyc(3);
    st(DPS_F_INLOSS, 1'b1, 1'b1, 1'b0, DPS_F_NONE);
    clr;
    wr_p(DPS_IDX_INLOSS_SEL, DPS_OFF, 1'b0);
    cyc(1);
    loss <= 2'h1;
    cyc(4);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
    // output loss: just under and at its floor
    wr_p(DPS_IDX_OUTLOSS_SEL, DPS_ON, 1'b0);
    cyc(1);
    loss <= 2'h2;
    cur <= 16'h0009;
    cyc(4);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
    cyc(1);
    cur <= 16'h000a;
    cyc(3);
    st(DPS_F_OUTLOSS, 1'b1, 1'b1, 1'b0, DPS_F_NONE);
    clr;
    // leakage: off by default, then enabled
    cyc(1);
    leak <= DPS_LEAK_PCT;
    cyc(4);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
    wr_p(DPS_IDX_LEAK_SEL, DPS_ON, 1'b0);
    cyc(2);
    st(DPS_F_LEAK, 1'b1, 1'b1, 1'b0, DPS_F_NONE);
    clr;
    // over-torque from run, decel; vector mode reads torque, not current
    wr_p(DPS_IDX_HT_SEL, DPS_DET_AT_RUN, 1'b0);
    wr_p(DPS_IDX_HT_ACT, DPS_ACT_DECEL, 1'b0);
    wr_p(DPS_IDX_HT_LVL, 16'h0064, 1'b0);
    wr_p(DPS_IDX_HT_TIME, 16'h0002, 1'b0);
    cyc(1);
    f1 <= DPS_DO_HI_TORQUE;
    f2 <= DPS_DO_LO_TORQUE;
    mode <= 2'h2;
    cur <= 16'h0078;
    trq <= 16'h0032;
    run <= 1'b1;
    cyc(20);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
    cyc(1);
    mode <= DPS_MODE_VF;
    cyc(2);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
    cyc(20);
    st(DPS_F_HT, 1'b1, 1'b0, 1'b1, DPS_F_NONE);
    chk("relay_one", 16'h0001, {15'h0000, r1});
    clr;
    // low-torque at speed, warning only; window closes when run drops
    wr_p(DPS_IDX_LT_SEL, DPS_DET_AT_SPEED, 1'b0);
    wr_p(DPS_IDX_LT_ACT, DPS_ACT_WARN, 1'b0);
    cyc(1);
    cur <= 16'h000a;
    run <= 1'b1;
    cyc(20);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_LT);
    chk("relay_two", 16'h0001, {15'h0000, r2});
    cyc(1);
    run <= 1'b0;
    cyc(4);
    st(DPS_F_NONE, 1'b0, 1'b0, 1'b0, DPS_F_NONE);
    report_and_stop;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clock_in);
    bad_count++;
    report_and_stop;
  end
endmodule
